// File: core/fapc_pkg.sv
package fapc_pkg;

   // ***************************************************************
   // Register addresses on the extended data bus
   // ***************************************************************
   localparam logic [15:0] MEM_CFG_ADDR  = 16'hfc00;
   localparam logic [15:0] CMD_ADDR      = 16'hfc01;
   localparam logic [15:0] DATA_ADDR     = 16'hfc02;
   localparam logic [15:0] LOCK_ADDR     = 16'hfc03;
   localparam logic [15:0] PART_ADDR     = 16'hfc04;
   localparam logic [15:0] PTR_LOW_ADDR  = 16'hfc05;
   localparam logic [15:0] PTR_HIGH_ADDR = 16'hfc06;

   // ***************************************************************
   // Reset values and field positions
   // ***************************************************************
   localparam logic [7:0] PART_RST      = 8'h80;
   localparam logic [7:0] LATCH_ERASED  = 8'hff;
   localparam int         CMD_INFO_BIT  = 7;
   localparam int         CMD_CLR_BIT   = 3;
   localparam int         CFG_SLEEP_BIT = 6;
   localparam int         CFG_BOOT_BIT  = 0;
   localparam int         GRANULE_SHIFT = 7;

   // ***************************************************************
   // Lock codes and command codes
   // ***************************************************************
   localparam logic [7:0] UNLOCK_CFG  = 8'h28;
   localparam logic [7:0] UNLOCK_PROG = 8'h29;
   localparam logic [7:0] UNLOCK_DATA = 8'h2a;
   localparam logic [7:0] RELOCK_ALL  = 8'haa;

   localparam logic [2:0] CMD_NONE       = 3'h0;
   localparam logic [2:0] CMD_DATA_READ  = 3'h1;
   localparam logic [2:0] CMD_DATA_WRITE = 3'h2;
   localparam logic [2:0] CMD_DATA_ERASE = 3'h3;
   localparam logic [2:0] CMD_SECT_ERASE = 3'h4;
   localparam logic [2:0] CMD_PROG_READ  = 3'h5;
   localparam logic [2:0] CMD_PROG_WRITE = 3'h6;
   localparam logic [2:0] CMD_PROG_ERASE = 3'h7;

   // ***************************************************************
   // Code space mapping of the external RAM
   // ***************************************************************
   localparam logic [15:0] XRAM_MAP_BASE = 16'h8000;
   localparam logic [15:0] XRAM_MAP_TOP  = 16'h81ff;
   localparam logic [15:0] BOOT_MAP_TOP  = 16'h01ff;
   localparam logic [5:0]  LAST_BYTE     = 6'h3f;

   typedef enum logic [1:0] {FOP_READ, FOP_PROG, FOP_ERASE} fapc_fop_t;

   typedef struct packed {
      logic       req;
      fapc_fop_t  op;
      logic [13:0] addr;
      logic [7:0] wdata;
   } fapc_freq_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } fapc_bus_t;

endpackage

// File: core/fapc_page_latch.sv
`timescale 1ns/1ps
module fapc_page_latch (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       clear,
   input  wire logic       wr_en,
   input  wire logic [5:0] wr_idx,
   input  wire logic [7:0] wr_data,
   input  wire logic [5:0] rd_idx,
   output logic      [7:0] rd_data
);
   import fapc_pkg::*;

   logic [7:0] latch_ff [64];

   // ***************************************************************
   // Page storage
   // ***************************************************************
   // Clear fills the page with the erased value so unwritten bytes program nothing.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 64; i++) latch_ff[i] <= LATCH_ERASED;
      end else begin
         for (int i = 0; i < 64; i++) begin
            if (clear) latch_ff[i] <= LATCH_ERASED;
            else if (wr_en && wr_idx == i[5:0]) latch_ff[i] <= wr_data;
         end
      end
   end

   // Read port used by the program sequence.
   assign rd_data = latch_ff[rd_idx];

   // ***************************************************************
   // Checks
   // ***************************************************************
   // Both ends of the page are watched, since a clear must reach every entry.
   clear_fill_a: assert property (@(posedge clk) disable iff (!resetn)
      clear |=> latch_ff[0] == LATCH_ERASED && latch_ff[63] == LATCH_ERASED)
      else $error("latch clear left data behind");
endmodule

// File: core/fapc_flash_ctrl.sv
`timescale 1ns/1ps
module fapc_flash_ctrl (
   input  wire logic                clk,
   input  wire logic                resetn,
   input  wire fapc_pkg::fapc_bus_t bus,
   output logic                     x_ready_ff,
   output logic                     x_rvalid_ff,
   output logic [7:0]               x_rdata_ff,
   output fapc_pkg::fapc_freq_t     fm_req_ff,
   input  wire logic                fm_ack,
   input  wire logic [7:0]          fm_rdata,
   input  wire logic                cpu_low_power,
   output logic                     flash_sleep_ff,
   input  wire logic                soft_reset,
   input  wire logic [15:0]         pc_addr,
   output logic                     code_from_ram_ff,
   output logic [8:0]               code_ram_addr_ff
);
   import fapc_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_PROG, ST_ERASE} fapc_state_t;

   // ***************************************************************
   // State
   // ***************************************************************
   fapc_state_t state_ff, nxt_state;
   logic [13:0] ptr_ff, nxt_ptr;
   logic [7:0]  part_ff, nxt_part;
   logic [2:0]  cmd_ff, nxt_cmd;
   logic        info_en_ff, nxt_info_en;
   logic        sleep_en_ff, nxt_sleep_en;
   logic        boot_bit_ff, nxt_boot_bit;
   logic        boot_ram_ff;
   logic        cfg_unl_ff, nxt_cfg_unl;
   logic        prog_unl_ff, nxt_prog_unl;
   logic        data_unl_ff, nxt_data_unl;
   logic [5:0]  idx_ff, nxt_idx;
   logic [7:0]  hold_ff, nxt_hold;
   logic        nxt_rvalid;
   logic [7:0]  nxt_rdata;
   fapc_freq_t  nxt_req;

   // Address of a flash byte after area translation.
   function automatic logic [13:0] phys(input logic [13:0] a, input logic data_area,
                                        input logic [7:0] part);
      logic [13:0] base;
      base = 14'(part) << GRANULE_SHIFT;
      phys = data_area ? 14'(a + base) : a;
   endfunction

   // ***************************************************************
   // Bus decode
   // ***************************************************************
   wire wr_go      = bus.wr && x_ready_ff;
   wire rd_go      = bus.rd && x_ready_ff;
   wire wr_cfg     = wr_go && bus.addr == MEM_CFG_ADDR;
   wire wr_cmd     = wr_go && bus.addr == CMD_ADDR;
   wire wr_dat     = wr_go && bus.addr == DATA_ADDR;
   wire wr_lock    = wr_go && bus.addr == LOCK_ADDR;
   wire wr_part    = wr_go && bus.addr == PART_ADDR;
   wire wr_ptl     = wr_go && bus.addr == PTR_LOW_ADDR;
   wire wr_pth     = wr_go && bus.addr == PTR_HIGH_ADDR;
   wire rd_dat     = rd_go && bus.addr == DATA_ADDR;
   wire [2:0] wcmd = bus.wdata[2:0];
   // Command field decode for the stored command and for the value being written.
   wire is_rd_cmd  = cmd_ff == CMD_DATA_READ || cmd_ff == CMD_PROG_READ;
   wire rd_in_data = cmd_ff == CMD_DATA_READ;
   wire w_data_op  = wcmd == CMD_DATA_WRITE || wcmd == CMD_DATA_ERASE;
   wire w_prog_op  = wcmd == CMD_PROG_WRITE || wcmd == CMD_PROG_ERASE
                     || wcmd == CMD_SECT_ERASE;
   wire w_write    = wcmd == CMD_DATA_WRITE || wcmd == CMD_PROG_WRITE;
   wire w_erase    = w_data_op && !w_write || w_prog_op && !w_write;
   // Program area work needs its unlock and a nonzero partition.
   wire allow      = w_data_op && data_unl_ff
                     || w_prog_op && prog_unl_ff && part_ff != 8'h00;
   wire start_op   = wr_cmd && (w_data_op || w_prog_op) && allow;
   // Page base for write and erase comes from the pointer top bits.
   wire [13:0] op_page = phys({ptr_ff[13:6], 6'h00}, w_data_op, part_ff);
   wire [5:0]  lat_idx;
   wire [7:0]  lat_q;

   // Register read selection.
   wire [7:0] lock_view = {4'h0, cfg_unl_ff, prog_unl_ff, data_unl_ff, 1'b0};
   wire [7:0] reg_q =
      bus.addr == MEM_CFG_ADDR  ? {1'b0, sleep_en_ff, 5'h00, boot_bit_ff} :
      bus.addr == CMD_ADDR      ? {info_en_ff, 4'h0, cmd_ff} :
      bus.addr == LOCK_ADDR     ? lock_view :
      bus.addr == PART_ADDR     ? part_ff :
      bus.addr == PTR_LOW_ADDR  ? ptr_ff[7:0] :
      bus.addr == PTR_HIGH_ADDR ? {2'b00, ptr_ff[13:8]} : 8'h00;

   assign lat_idx = state_ff == ST_PROG ? idx_ff : 6'h00;

   fapc_page_latch u_latch (
      .clk     (clk),
      .resetn  (resetn),
      .clear   (wr_cmd && bus.wdata[CMD_CLR_BIT]),
      .wr_en   (wr_dat),
      .wr_idx  (ptr_ff[5:0]),
      .wr_data (bus.wdata),
      .rd_idx  (lat_idx),
      .rd_data (lat_q)
   );

   // ***************************************************************
   // Next state
   // ***************************************************************
   // Only one flash operation runs at a time; the bus stays not ready until it ends.
   always_comb begin
      nxt_state    = state_ff;
      nxt_ptr      = ptr_ff;
      nxt_part     = wr_part ? bus.wdata : part_ff;
      nxt_cmd      = cmd_ff;
      nxt_info_en  = info_en_ff;
      nxt_sleep_en = wr_cfg ? bus.wdata[CFG_SLEEP_BIT] : sleep_en_ff;
      nxt_boot_bit = wr_cfg ? bus.wdata[CFG_BOOT_BIT] : boot_bit_ff;
      nxt_cfg_unl  = cfg_unl_ff;
      nxt_prog_unl = prog_unl_ff;
      nxt_data_unl = data_unl_ff;
      nxt_idx      = idx_ff;
      nxt_hold     = hold_ff;
      nxt_rvalid   = 1'b0;
      nxt_rdata    = x_rdata_ff;
      nxt_req      = fm_req_ff;
      if (wr_lock) begin
         unique case (bus.wdata)
            UNLOCK_CFG:  nxt_cfg_unl = 1'b1;
            UNLOCK_PROG: nxt_prog_unl = 1'b1;
            UNLOCK_DATA: nxt_data_unl = 1'b1;
            RELOCK_ALL: begin
               nxt_cfg_unl  = 1'b0;
               nxt_prog_unl = 1'b0;
               nxt_data_unl = 1'b0;
            end
            default: ;
         endcase
      end
      if (wr_ptl) nxt_ptr[7:0] = bus.wdata;
      if (wr_pth) nxt_ptr[13:8] = bus.wdata[5:0];
      if (wr_dat) nxt_ptr = 14'(ptr_ff + 14'h1);
      unique case (state_ff)
         ST_IDLE: begin
            if (wr_cmd) begin
               nxt_info_en = bus.wdata[CMD_INFO_BIT];
               // A refused erase leaves no command behind, like a finished one.
               nxt_cmd = (w_erase && !allow) ? CMD_NONE : wcmd;
            end
            if (start_op && w_write) begin
               nxt_state = ST_PROG;
               nxt_idx   = 6'h00;
               nxt_req   = '{req: 1'b0, op: FOP_PROG, addr: op_page, wdata: 8'h00};
            end else if (start_op) begin
               nxt_state = ST_ERASE;
               nxt_req   = '{req: 1'b1, op: FOP_ERASE, addr: op_page, wdata: 8'h00};
            end
            if (rd_dat && is_rd_cmd) begin
               nxt_state = ST_READ;
               nxt_req   = '{req: 1'b1, op: FOP_READ,
                             addr: phys(ptr_ff, rd_in_data, part_ff), wdata: 8'h00};
            end else if (rd_dat) begin
               nxt_rvalid = 1'b1;
               nxt_rdata  = hold_ff;
               nxt_ptr    = 14'(ptr_ff + 14'h1);
            end else if (rd_go) begin
               nxt_rvalid = 1'b1;
               nxt_rdata  = reg_q;
            end
         end
         ST_READ: begin
            if (fm_ack) begin
               nxt_req.req = 1'b0;
               nxt_state   = ST_IDLE;
               nxt_rvalid  = 1'b1;
               nxt_rdata   = fm_rdata;
               nxt_hold    = fm_rdata;
               nxt_ptr     = 14'(ptr_ff + 14'h1);
            end
         end
         ST_PROG: begin
            if (!fm_req_ff.req) begin
               nxt_req.req   = 1'b1;
               nxt_req.addr  = {fm_req_ff.addr[13:6], idx_ff};
               nxt_req.wdata = lat_q;
            end else if (fm_ack) begin
               nxt_req.req = 1'b0;
               nxt_idx     = 6'(idx_ff + 6'h1);
               if (idx_ff == LAST_BYTE) nxt_state = ST_IDLE;
            end
         end
         ST_ERASE: begin
            if (fm_ack) begin
               nxt_req.req = 1'b0;
               nxt_state   = ST_IDLE;
               nxt_cmd     = CMD_NONE;
            end
         end
      endcase
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff    <= ST_IDLE;
         ptr_ff      <= 14'h0000;
         part_ff     <= PART_RST;
         cmd_ff      <= CMD_NONE;
         info_en_ff  <= 1'b0;
         sleep_en_ff <= 1'b0;
         boot_bit_ff <= 1'b0;
         cfg_unl_ff  <= 1'b0;
         prog_unl_ff <= 1'b0;
         data_unl_ff <= 1'b0;
         idx_ff      <= 6'h00;
         hold_ff     <= 8'h00;
         x_ready_ff  <= 1'b1;
         x_rvalid_ff <= 1'b0;
         x_rdata_ff  <= 8'h00;
         fm_req_ff   <= '0;
      end else begin
         state_ff    <= nxt_state;
         ptr_ff      <= nxt_ptr;
         part_ff     <= nxt_part;
         cmd_ff      <= nxt_cmd;
         info_en_ff  <= nxt_info_en;
         sleep_en_ff <= nxt_sleep_en;
         boot_bit_ff <= nxt_boot_bit;
         cfg_unl_ff  <= nxt_cfg_unl;
         prog_unl_ff <= nxt_prog_unl;
         data_unl_ff <= nxt_data_unl;
         idx_ff      <= nxt_idx;
         hold_ff     <= nxt_hold;
         x_ready_ff  <= nxt_state == ST_IDLE;
         x_rvalid_ff <= nxt_rvalid;
         x_rdata_ff  <= nxt_rdata;
         fm_req_ff   <= nxt_req;
      end
   end

   // ***************************************************************
   // Code space mapping and flash sleep
   // ***************************************************************
   // The boot choice is sampled only on soft reset so a later write cannot move code.
   wire in_map  = pc_addr >= XRAM_MAP_BASE && pc_addr <= XRAM_MAP_TOP;
   wire in_boot = boot_ram_ff && pc_addr <= BOOT_MAP_TOP;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         boot_ram_ff      <= 1'b0;
         code_from_ram_ff <= 1'b0;
         code_ram_addr_ff <= 9'h000;
         flash_sleep_ff   <= 1'b0;
      end else begin
         if (soft_reset) boot_ram_ff <= boot_bit_ff;
         code_from_ram_ff <= in_map || in_boot;
         code_ram_addr_ff <= pc_addr[8:0];
         flash_sleep_ff   <= sleep_en_ff && cpu_low_power;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   lock_flag_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_lock && bus.wdata == UNLOCK_DATA |=> data_unl_ff)
      else $error("data unlock code did not set the flag");
   relock_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_lock && bus.wdata == RELOCK_ALL |=> !cfg_unl_ff && !prog_unl_ff && !data_unl_ff)
      else $error("relock code left an area open");
   ptr_wr_inc_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_dat |=> ptr_ff == 14'($past(ptr_ff) + 14'h1))
      else $error("pointer did not advance after data write");
   ptr_rd_inc_a: assert property (@(posedge clk) disable iff (!resetn)
      state_ff == ST_READ && fm_ack |=> ptr_ff == 14'($past(ptr_ff) + 14'h1) && x_rvalid_ff)
      else $error("pointer did not advance after data read");
   locked_op_a: assert property (@(posedge clk) disable iff (!resetn)
      wr_cmd && (w_data_op || w_prog_op) && !allow |=> state_ff == ST_IDLE)
      else $error("locked area accepted a write or erase");
   erase_clr_a: assert property (@(posedge clk) disable iff (!resetn)
      state_ff == ST_ERASE && fm_ack |=> cmd_ff == CMD_NONE ##1 x_ready_ff)
      else $error("erase finished but command not cleared");
   busy_stall_a: assert property (@(posedge clk) disable iff (!resetn)
      state_ff != ST_IDLE |-> !x_ready_ff)
      else $error("bus ready during flash operation");
   data_xlate_a: assert property (@(posedge clk) disable iff (!resetn)
      rd_dat && cmd_ff == CMD_DATA_READ && x_ready_ff
      |=> fm_req_ff.addr == 14'($past(ptr_ff) + (14'($past(part_ff)) << 7)))
      else $error("data read address not translated");
   ram_map_a: assert property (@(posedge clk) disable iff (!resetn)
      pc_addr == XRAM_MAP_BASE |=> code_from_ram_ff && code_ram_addr_ff == 9'h000)
      else $error("mapped RAM window not selected");
endmodule

// File: verification/test_flash_area_programming_control.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_flash_area_programming_control;
   import fapc_pkg::*;
   logic        clk;
   logic        resetn;
   fapc_bus_t   bus;
   logic        x_ready_ff;
   logic        x_rvalid_ff;
   logic [7:0]  x_rdata_ff;
   fapc_freq_t  fm_req_ff;
   logic        fm_ack;
   logic [7:0]  fm_rdata;
   logic        cpu_low_power;
   logic        flash_sleep_ff;
   logic        soft_reset;
   logic [15:0] pc_addr;
   logic        code_from_ram_ff;
   logic [8:0]  code_ram_addr_ff;
   int          error_cnt;
   int          comparisons;
   int          cycles;
   int          dly;
   logic [31:0] seed;
   logic [23:0] log_q[$];

   fapc_flash_ctrl i_dut (.clk(clk), .resetn(resetn), .bus(bus), .x_ready_ff(x_ready_ff),
      .x_rvalid_ff(x_rvalid_ff), .x_rdata_ff(x_rdata_ff), .fm_req_ff(fm_req_ff),
      .fm_ack(fm_ack), .fm_rdata(fm_rdata), .cpu_low_power(cpu_low_power),
      .flash_sleep_ff(flash_sleep_ff), .soft_reset(soft_reset), .pc_addr(pc_addr),
      .code_from_ram_ff(code_from_ram_ff), .code_ram_addr_ff(code_ram_addr_ff));

   // ***************************************************************
   // Helpers and the flash array stand-in
   // ***************************************************************
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction

   // Each flash byte is a fixed mix of its address, so any single wrong address bit shows up.
   function automatic logic [7:0] mem_byte(input logic [13:0] a);
      return a[7:0] ^ {2'h0, a[13:8]};
   endfunction

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // The array answers after a random 0..3 cycle wait and logs every request it takes.
   initial begin
      dly = 0;
      forever begin
         @(posedge clk);
         #2;
         fm_ack = 1'b0;
         fm_rdata = ~fm_rdata;
         if (fm_req_ff.req === 1'b1) begin
            if (dly == 0) begin
               log_q.push_back({fm_req_ff.op, fm_req_ff.addr, fm_req_ff.wdata});
               fm_rdata = mem_byte(fm_req_ff.addr);
               fm_ack = 1'b1;
               dly = rnd() % 4;
            end else dly--;
         end
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         error_cnt++;
         complete_run();
      end
   end

   // One access; an idle edge always follows so the bus never changes twice at once.
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int n;
      n = 0;
      q = 8'h00;
      while (x_ready_ff !== 1'b1 && n < 900) begin
         @(posedge clk);
         #2;
         n++;
      end
      bus = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk);
      #2;
      bus = '0;
      while (!w && x_rvalid_ff !== 1'b1 && n < 900) begin
         @(posedge clk);
         #2;
         n++;
      end
      if (!w) q = x_rdata_ff;
      @(posedge clk);
      #2;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      acc(1'b1, a, d, q);
   endtask

   task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] q;
      acc(1'b0, a, 8'h00, q);
      `CHK(q, e)
   endtask

   task automatic set_ptr(input logic [13:0] p);
      wr(PTR_HIGH_ADDR, {2'h0, p[13:8]});
      wr(PTR_LOW_ADDR, p[7:0]);
   endtask

   // A read run through the data port; data-area addresses are offset by the partition.
   task automatic read_run(input logic [2:0] cmd, input logic [7:0] part,
                           input logic [13:0] ptr, input int n);
      logic [7:0]  q;
      logic [13:0] pa;
      wr(PART_ADDR, part);
      wr(CMD_ADDR, 8'h00);
      set_ptr(ptr);
      wr(CMD_ADDR, {5'h00, cmd});
      log_q.delete();
      for (int i = 0; i < n; i++) begin
         pa = ptr + 14'(i) + ((cmd == CMD_DATA_READ) ? {part[6:0], 7'h00} : 14'h0000);
         acc(1'b0, DATA_ADDR, 8'h00, q);
         `CHK(q, mem_byte(pa))
         `CHK(log_q[i][23:8], {FOP_READ, pa})
      end
      rdchk(PTR_LOW_ADDR, 8'(ptr + 14'(n)));
   endtask

   // A whole page load and program; the latch index follows the pointer from zero.
   task automatic page_write(input logic [2:0] cmd, input logic [7:0] unl,
                             input logic [7:0] part, input logic [7:0] page);
      logic [7:0]  bytes[64];
      logic [13:0] pa;
      wr(PART_ADDR, part);
      wr(CMD_ADDR, 8'h00);
      wr(LOCK_ADDR, unl);
      set_ptr(14'h0000);
      wr(CMD_ADDR, 8'h08);
      foreach (bytes[i]) begin
         bytes[i] = rnd();
         wr(DATA_ADDR, bytes[i]);
      end
      rdchk(PTR_LOW_ADDR, 8'h40);
      set_ptr({page, 6'h00});
      log_q.delete();
      wr(CMD_ADDR, {5'h00, cmd});
      rdchk(CMD_ADDR, {5'h00, cmd});
      `CHK(log_q.size(), 64)
      foreach (bytes[i]) begin
         pa = {page, 6'(i)} + ((cmd == CMD_DATA_WRITE) ? {part[6:0], 7'h00} : 14'h0000);
         `CHK(log_q[i], {FOP_PROG, pa, bytes[i]})
      end
      wr(LOCK_ADDR, RELOCK_ALL);
   endtask

   // An erase; a refused one must start nothing and leave the array alone.
   task automatic erase(input logic [2:0] cmd, input logic [7:0] unl, input logic [7:0] part,
                        input logic [7:0] page, input int exp_n);
      logic [13:0] pa;
      pa = {page, 6'h00} + ((cmd == CMD_DATA_ERASE) ? {part[6:0], 7'h00} : 14'h0000);
      wr(PART_ADDR, part);
      wr(CMD_ADDR, 8'h00);
      wr(LOCK_ADDR, unl);
      wr(CMD_ADDR, 8'h08);
      set_ptr({page, 6'h00});
      log_q.delete();
      wr(CMD_ADDR, {5'h00, cmd});
      rdchk(CMD_ADDR, 8'h00);
      repeat (20) @(posedge clk);
      #2;
      `CHK(log_q.size(), exp_n)
      if (exp_n == 1) `CHK(log_q[0][23:14], {FOP_ERASE, pa[13:6]})
      wr(LOCK_ADDR, RELOCK_ALL);
   endtask

   task automatic fetch(input logic [15:0] pc, input logic e);
      pc_addr = pc;
      @(posedge clk);
      #2;
      `CHK(code_from_ram_ff, e)
      `CHK(code_ram_addr_ff, pc[8:0])
   endtask

   task automatic complete_run();
      $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      logic [7:0] codes[4] = '{8'h28, 8'h29, 8'h2a, 8'haa};
      logic [7:0] flags[4] = '{8'h08, 8'h04, 8'h02, 8'h00};
      logic [7:0] part;
      seed = 32'h144a;
      resetn = 1'b0; bus = '0; fm_ack = 1'b0; fm_rdata = 8'h00;
      cpu_low_power = 1'b0; soft_reset = 1'b0; pc_addr = 16'h0000;
      error_cnt = 0; comparisons = 0; cycles = 0;
      repeat (10) @(posedge clk);
      #2;
      resetn = 1'b1;
      rdchk(PART_ADDR, PART_RST);
      rdchk(PTR_HIGH_ADDR, 8'h00);
      rdchk(LOCK_ADDR, 8'h00);
      rdchk(16'hfc07, 8'h00);
      wr(PTR_HIGH_ADDR, 8'hff);
      rdchk(PTR_HIGH_ADDR, 8'h3f);
      foreach (codes[i]) begin
         wr(LOCK_ADDR, codes[i]);
         rdchk(LOCK_ADDR, flags[i]);
         wr(LOCK_ADDR, RELOCK_ALL);
      end
      $display("test registers done");
      part = (rnd() % 8'h7f) + 8'h01;
      read_run(CMD_DATA_READ, part, 14'(rnd()), 70);
      read_run(CMD_DATA_READ, 8'h00, 14'h3ffe, 3);
      read_run(CMD_PROG_READ, part, {6'h12, rnd()}, 5);
      $display("test reads done");
      page_write(CMD_DATA_WRITE, UNLOCK_DATA, part, 8'h01);
      page_write(CMD_PROG_WRITE, UNLOCK_PROG, 8'h10, 8'h05);
      erase(CMD_DATA_ERASE, UNLOCK_DATA, part, 8'h02, 1);
      erase(CMD_PROG_ERASE, UNLOCK_PROG, 8'h10, 8'h03, 1);
      erase(CMD_SECT_ERASE, UNLOCK_PROG, 8'h10, 8'h04, 1);
      erase(CMD_DATA_ERASE, RELOCK_ALL, part, 8'h02, 0);
      erase(CMD_PROG_ERASE, UNLOCK_DATA, 8'h10, 8'h03, 0);
      $display("test program and erase done");
      fetch(16'h8000, 1'b1);
      fetch(16'h81ff, 1'b1);
      fetch(16'h8200, 1'b0);
      fetch(16'h0100, 1'b0);
      wr(MEM_CFG_ADDR, 8'h41);
      soft_reset = 1'b1;
      @(posedge clk);
      #2;
      soft_reset = 1'b0;
      fetch(16'h01ff, 1'b1);
      fetch(16'h0200, 1'b0);
      cpu_low_power = 1'b1;
      @(posedge clk);
      #2;
      `CHK(flash_sleep_ff, 1'b1)
      $display("test code mapping done");
      complete_run();
   end
endmodule
